/* sim/ddrpin_ctrl_model.sv */
`timescale 1ns/10ps
// Controller side of the pins: replays one queued cycle per falling edge
module ddrpin_ctrl_model import ddrpin_pkg::*; (
  // Clock
  input  wire logic        clk_sys,
  // Command, address and data pins toward the device
  output logic             cke,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [2:0]       ba,
  output logic [13:0]      addr,
  output logic             odt,
  output logic [7:0]       dq_in,
  output logic             dm_in
);
  typedef struct packed {
    logic [3:0]  c;
    logic [2:0]  b;
    logic [13:0] a;
    logic        k;
    logic        v;
    logic [7:0]  d;
    logic        m;
  } ddrpin_cyc_s;
  ddrpin_cyc_s q [$];
  ddrpin_cyc_s cur;
  logic        odt_lvl = 1'b0;

  initial {cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm_in, dq_in} = 32'hf800005a;

  task automatic put(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a,
                     input logic k = 1'b1, input logic v = 1'b0,
                     input logic [7:0] d = 8'h00, input logic m = 1'b0);
    q.push_back('{c, b, a, k, v, d, m});
  endtask

  // Released data lines toggle every cycle so stale data never looks valid
  always @(negedge clk_sys) begin
    cur = '{DDRPIN_CMD_NOP, 3'h0, 14'h0000, 1'b1, 1'b0, 8'h00, 1'b0};
    if (q.size() != 0) cur = q.pop_front();
    {cs_n, ras_n, cas_n, we_n} <= cur.c;
    cke   <= cur.k;
    ba    <= cur.b;
    addr  <= cur.a;
    odt   <= odt_lvl;
    dq_in <= cur.v ? cur.d : ~dq_in;
    dm_in <= cur.v ? cur.m : ~dm_in;
  end
endmodule

/* sim/ddrpin_top_bench.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) check(n, e, g)
module ddrpin_top_bench import ddrpin_pkg::*;;
  logic        clk_sys = 1'b0;
  logic        arst_n  = 1'b0;
  logic        cke, cs_n, ras_n, cas_n, we_n, odt, dm_in, dq_oe_n, dqs_out, dqs_out_n;
  logic        dqs_oe_n, self_refresh, term_dq, term_dqs, term_dm_tdqs, term_tdqs_n;
  logic        term_ca, tdqs_mode, auto_pre, pre_all, pre_valid;
  logic [2:0]  ba, pre_bank, mrs_sel, bk;
  logic [13:0] addr, open_row, mrs_op, mr1, mr2, op, row_m;
  logic [7:0]  dq_in, dq_out;
  logic [7:0]  mem_m [64];
  logic [3:0]  pv_q [$];
  logic [13:0] t1 [4] = '{14'h0000, 14'h0804, 14'h0240, 14'h0800};
  logic [13:0] t2 [4] = '{14'h01ff, 14'h0000, 14'h0000, 14'h0600};
  logic [3:0]  cmds [4] = '{4'h8, 4'hb, DDRPIN_CMD_ZQ, DDRPIN_CMD_REF};
  logic [31:0] rng = 32'hfb492806;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          i, j, n;

  always #2 clk_sys = ~clk_sys;

  ddrpin_ctrl_model ctrl (.clk_sys, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .odt,
                          .dq_in, .dm_in);
  ddrpin_top #(.COL_AW(6)) DUT (.clk_sys, .arst_n, .cke, .cs_n, .ras_n, .cas_n, .we_n,
    .ba, .addr, .odt, .dq_in, .dq_out, .dq_oe_n, .dm_in, .dqs_out, .dqs_out_n,
    .dqs_oe_n, .self_refresh, .term_dq, .term_dqs, .term_dm_tdqs, .term_tdqs_n,
    .term_ca, .tdqs_mode, .auto_pre, .pre_bank, .pre_all, .pre_valid, .open_row,
    .mrs_sel, .mrs_op);

  // Precharge pulses last one cycle, so they are queued as they happen
  always @(posedge clk_sys) if (pre_valid === 1'b1) pv_q.push_back({pre_all, pre_bank});

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic complete_run();
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic tk(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask

  // Queue always empties on its own; the settle covers the two-flop sync
  task automatic drain();
    for (int k = 0; k < 40 && ctrl.q.size() != 0; k++) @(posedge clk_sys);
    tk(6);
  endtask

  task automatic rst_chk();
    `CHK("dq_oe_n", 1, dq_oe_n);
    `CHK("dqs_oe_n", 1, dqs_oe_n);
    `CHK("dqs_out_n", 1, dqs_out_n);
    `CHK("status", 0, {self_refresh, term_dq, tdqs_mode, open_row, mrs_op});
    mr1 = 14'h0000;
    mr2 = 14'h0000;
  endtask

  task automatic term_chk(input logic sr);
    logic t;
    t = odt & !sr & (|{mr1[2], mr1[6], mr1[9], mr2[10:9]});
    `CHK("term_dq", t, term_dq);
    `CHK("term_dqs", t, term_dqs);
    `CHK("term_dm_tdqs", t, term_dm_tdqs);
    `CHK("term_tdqs_n", t & mr1[11], term_tdqs_n);
    `CHK("tdqs_mode", mr1[11], tdqs_mode);
    `CHK("term_ca", 0, term_ca);
  endtask

  task automatic mrs(input logic [2:0] b, input logic [13:0] o);
    ctrl.put(DDRPIN_CMD_MRS, b, o);
    drain();
    if (b == 3'h1) mr1 = o;
    if (b == 3'h2) mr2 = o;
    `CHK("mrs_sel", b, mrs_sel);
    `CHK("mrs_op", o, mrs_op);
  endtask

  task automatic ap_chk(input logic [2:0] b, input logic ap);
    `CHK("auto_pre", ap, auto_pre);
    `CHK("pre_count", ap, pv_q.size());
    if (ap) `CHK("pre_scope", {1'b0, b}, pv_q[0]);
  endtask

  task automatic wr(input logic [2:0] b, input logic [9:0] col, input logic bc,
                    input logic ap, input logic msk);
    logic [7:0] d;
    logic       m;
    n = bc ? 8 : 4;
    pv_q.delete();
    ctrl.put(DDRPIN_CMD_WR, b, {1'b0, bc, 1'b0, ap, col});
    for (j = 0; j < n; j++) begin
      d = 8'(rnd());
      m = msk & rng[9];
      ctrl.put(DDRPIN_CMD_NOP, b, 14'h0000, 1'b1, 1'b1, d, m);
      if (!m) mem_m[6'(col + j)] = d;
    end
    drain();
    ap_chk(b, ap);
  endtask

  task automatic rd(input logic [2:0] b, input logic [9:0] col, input logic bc,
                    input logic ap);
    logic s;
    n = bc ? 8 : 4;
    pv_q.delete();
    ctrl.put(DDRPIN_CMD_RD, b, {1'b0, bc, 1'b0, ap, col});
    for (j = 0; j < 12 && dq_oe_n !== 1'b0; j++) tk(1);
    s = 1'b0;
    for (j = 0; j < n; j++) begin
      `CHK("dq_oe_n", 0, dq_oe_n);
      `CHK("dq_out", mem_m[6'(col + j)], dq_out);
      `CHK("dqs_toggle", !s, dqs_out);
      `CHK("dqs_pair", !dqs_out, dqs_out_n);
      s = dqs_out;
      tk(1);
    end
    `CHK("dq_release", 1, dq_oe_n);
    drain();
    ap_chk(b, ap);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_chk();
    @(negedge clk_sys) arst_n = 1'b1;
    drain();
    for (i = 0; i < 4; i++) begin
      mrs(3'h1, t1[i]);
      mrs(3'h2, t2[i]);
      for (j = 0; j < 2; j++) begin
        ctrl.odt_lvl = j[0];
        drain();
        term_chk(1'b0);
      end
    end
    mrs(3'h3, 14'h3fff);
    term_chk(1'b0);
    // Self refresh with termination enabled and odt high
    ctrl.put(DDRPIN_CMD_REF, 3'h0, 14'h0000, 1'b0);
    for (j = 0; j < 12; j++) ctrl.put(DDRPIN_CMD_NOP, 3'h0, 14'h0000, 1'b0);
    tk(8);
    `CHK("self_refresh", 1, self_refresh);
    term_chk(1'b1);
    drain();
    `CHK("self_refresh", 0, self_refresh);
    term_chk(1'b0);
    for (i = 0; i < 8; i++) wr(3'(i), 10'(i * 8), 1'b1, 1'b0, 1'b0);
    row_m = 14'(rnd());
    ctrl.put(DDRPIN_CMD_ACT, 3'h5, row_m);
    drain();
    `CHK("open_row", row_m, open_row);
    for (i = 0; i < 4; i++) begin
      pv_q.delete();
      ctrl.put(cmds[i], 3'h2, ~row_m);
      drain();
      `CHK("open_row", row_m, open_row);
      `CHK("mrs_op", 14'h3fff, mrs_op);
      `CHK("pre_count", 0, pv_q.size());
    end
    for (i = 0; i < 2; i++) begin
      pv_q.delete();
      bk = 3'(rnd());
      op = {3'h0, i[0], 10'(rnd())};
      ctrl.put(DDRPIN_CMD_PRE, bk, op);
      drain();
      `CHK("pre_count", 1, pv_q.size());
      `CHK("pre_all", i[0], pv_q[0][3]);
      if (i == 0) `CHK("pre_bank", bk, pv_q[0][2:0]);
    end
    for (i = 0; i < 12; i++) begin
      bk = 3'(rnd());
      op = 14'(rnd());
      wr(bk, op[9:0], i[0], i[1], 1'b1);
      rd(bk, op[9:0], i[1], i[0]);
    end
    @(negedge clk_sys) arst_n = 1'b0;
    #1;
    rst_chk();
    tk(3);
    @(negedge clk_sys) arst_n = 1'b1;
    drain();
    term_chk(1'b0);
    complete_run();
  end

  initial begin
    #60000;
    n_fail++;
    complete_run();
  end
endmodule

/* src/ddrpin_mem.sv */
`timescale 1ns/10ps
// Byte array with per-byte write strobe and registered read
module ddrpin_mem #(
  parameter int AW = 6
) (
  // Clock
  input  wire logic          clk_sys,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  // Read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);

  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

/* src/ddrpin_params.svh */
`ifndef DDRPIN_PARAMS_SVH
`define DDRPIN_PARAMS_SVH

// Address bit positions
`define DDRPIN_AP_BIT       10
`define DDRPIN_BC_BIT       12
`define DDRPIN_TDQS_BIT     11
// Mode register numbers on the bank inputs
`define DDRPIN_MR1          3'h1
`define DDRPIN_MR2          3'h2
// Termination select fields: MR1 A9,A6,A2 and MR2 A10:A9
`define DDRPIN_MR1_RTT_B0   2
`define DDRPIN_MR1_RTT_B1   6
`define DDRPIN_MR1_RTT_B2   9
`define DDRPIN_MR2_WR_LO    9
`define DDRPIN_MR2_WR_HI    10
// Burst beat counts
`define DDRPIN_BEATS_BC4    4'h4
`define DDRPIN_BEATS_BL8    4'h8
`define DDRPIN_BEAT_ZERO    4'h0
`define DDRPIN_BEAT_ONE     4'h1
// Reset values
`define DDRPIN_ADDR_RST     14'h0000
`define DDRPIN_BANK_RST     3'h0
`define DDRPIN_BYTE_RST     8'h00
`define DDRPIN_TERM_RST     12'h000

`endif

/* src/ddrpin_pkg.sv */
package ddrpin_pkg;

  // Command code {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    DDRPIN_CMD_MRS = 4'b0000,
    DDRPIN_CMD_REF = 4'b0001,
    DDRPIN_CMD_PRE = 4'b0010,
    DDRPIN_CMD_ACT = 4'b0011,
    DDRPIN_CMD_WR  = 4'b0100,
    DDRPIN_CMD_RD  = 4'b0101,
    DDRPIN_CMD_ZQ  = 4'b0110,
    DDRPIN_CMD_NOP = 4'b0111
  } ddrpin_cmd_e;

  typedef enum logic [1:0] {
    DDRPIN_ST_IDLE  = 2'b00,
    DDRPIN_ST_WRITE = 2'b01,
    DDRPIN_ST_READ  = 2'b10,
    DDRPIN_ST_SELF  = 2'b11
  } ddrpin_state_e;

endpackage

/* src/ddrpin_sync.sv */
`timescale 1ns/10ps
// Two-stage synchroniser for pin inputs
module ddrpin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  // Data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

/* src/ddrpin_top.sv */
`timescale 1ns/10ps
// Function
// - Registered odt high turns termination on, low leaves it off.
// - Termination applies only to dq, strobe pair, dm/tdqs and tdqs_n.
// - Odt ignored when mode registers disable termination or in self refresh.
// - A write beat with dm high is not stored.
// - Data mask is sampled on both strobe edges; here dm_in is taken once per rising clk_sys edge.
// - MR1 A11 high gives tdqs pair strobe termination; low means dm.
// - Bank inputs pick bank, or mode register during mode set.
// - Address carries row, column or op-code depending on command.
// - Precharge with A10 low hits named bank, high hits all banks.
// - A12 low on read or write chops the burst.
// - Read strobe is edge aligned; write strobe centred in data; writes here have no strobe input, data taken on rising clk_sys.
// - Strobe is always a differential pair.
// - Reset low clears the interface asynchronously; contents treated lost.
// - Eight bidirectional data lines, driven by device only on reads.
// - Input-only pins have no termination.
// - Commands ignored while chip select is high.
// - Address and control sampled on the rising clock edge.
`include "ddrpin_params.svh"
module ddrpin_top
  import ddrpin_pkg::*;
#(
  parameter int COL_AW = 6
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // Command and address pins
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [13:0] addr,
  input  wire logic        odt,
  // Data pins, one beat per rising edge of clk_sys in this model
  input  wire logic [7:0]  dq_in,
  output logic      [7:0]  dq_out,
  output logic             dq_oe_n,
  input  wire logic        dm_in,
  output logic             dqs_out,
  output logic             dqs_out_n,
  output logic             dqs_oe_n,
  // Status
  output logic             self_refresh,
  output logic             term_dq,
  output logic             term_dqs,
  output logic             term_dm_tdqs,
  output logic             term_tdqs_n,
  output logic             term_ca,
  output logic             tdqs_mode,
  output logic             auto_pre,
  output logic [2:0]       pre_bank,
  output logic             pre_all,
  output logic             pre_valid,
  output logic [13:0]      open_row,
  output logic [2:0]       mrs_sel,
  output logic [13:0]      mrs_op
);

  //------------------------------------------------------------
  // Pin synchronisers
  //------------------------------------------------------------
  logic [2:0]  ba_s;
  logic [13:0] addr_s;
  logic [7:0]  dq_s;
  logic        cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, odt_s, dm_s;
  logic        cke_d;

  ddrpin_sync #(.WIDTH(32)) u_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .din     ({cke, cs_n, ras_n, cas_n, we_n, odt, dm_in, ba, addr, dq_in}),
    .dout    ({cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, odt_s, dm_s, ba_s, addr_s, dq_s})
  );

  //------------------------------------------------------------
  // Command decode
  //------------------------------------------------------------
  function automatic logic cmd_is(input logic [3:0] code, input ddrpin_cmd_e c);
    cmd_is = (code == c);
  endfunction

  wire [3:0] cmd_code = {cs_n_s, ras_n_s, cas_n_s, we_n_s};
  // Chip select high maps outside every code used below, so it is masked
  wire       cmd_live = cke_s && !cs_n_s;
  wire       is_act   = cmd_live && cmd_is(cmd_code, DDRPIN_CMD_ACT);
  wire       is_rd    = cmd_live && cmd_is(cmd_code, DDRPIN_CMD_RD);
  wire       is_wr    = cmd_live && cmd_is(cmd_code, DDRPIN_CMD_WR);
  wire       is_pre   = cmd_live && cmd_is(cmd_code, DDRPIN_CMD_PRE);
  wire       is_mrs   = cmd_live && cmd_is(cmd_code, DDRPIN_CMD_MRS);
  // Self refresh entry: refresh code with cke falling, seen only through the synchroniser
  wire       is_sre   = !cs_n_s && !cke_s && cke_d &&
                        cmd_is(cmd_code, DDRPIN_CMD_REF);
  wire       ap_bit   = addr_s[`DDRPIN_AP_BIT];
  wire       chop     = !addr_s[`DDRPIN_BC_BIT];
  wire [3:0] beats    = chop ? `DDRPIN_BEATS_BC4 : `DDRPIN_BEATS_BL8;

  //------------------------------------------------------------
  // Mode register shadows
  //------------------------------------------------------------
  logic [13:0] mr1, mr2;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mr1 <= `DDRPIN_ADDR_RST;
      mr2 <= `DDRPIN_ADDR_RST;
    end else if (is_mrs && ba_s == `DDRPIN_MR1) begin
      mr1 <= addr_s;
    end else if (is_mrs && ba_s == `DDRPIN_MR2) begin
      mr2 <= addr_s;
    end
  end

  wire rtt_nom_on = mr1[`DDRPIN_MR1_RTT_B0] | mr1[`DDRPIN_MR1_RTT_B1] |
                    mr1[`DDRPIN_MR1_RTT_B2];
  wire rtt_wr_on  = mr2[`DDRPIN_MR2_WR_LO] | mr2[`DDRPIN_MR2_WR_HI];
  wire tdqs_en    = mr1[`DDRPIN_TDQS_BIT];
  wire st_self;
  // Odt only counts when termination is enabled and not in self refresh
  wire odt_eff    = odt_s && (rtt_nom_on || rtt_wr_on) && !st_self;

  //------------------------------------------------------------
  // Burst state machine
  //------------------------------------------------------------
  ddrpin_state_e state, next_state;
  logic [3:0]    beat_cnt, next_beat_cnt;
  logic [2:0]    cur_bank;
  logic [COL_AW-1:0] col;
  assign st_self = (state == DDRPIN_ST_SELF);
  wire burst_last = (beat_cnt == `DDRPIN_BEAT_ONE);

  always_comb begin
    next_state    = state;
    next_beat_cnt = beat_cnt;
    unique case (state)
      DDRPIN_ST_IDLE: begin
        if (is_sre) begin
          next_state = DDRPIN_ST_SELF;
        end else if (is_wr) begin
          next_state    = DDRPIN_ST_WRITE;
          next_beat_cnt = beats;
        end else if (is_rd) begin
          next_state    = DDRPIN_ST_READ;
          next_beat_cnt = beats;
        end
      end
      DDRPIN_ST_WRITE, DDRPIN_ST_READ: begin
        next_beat_cnt = beat_cnt - `DDRPIN_BEAT_ONE;
        if (burst_last) begin
          next_state = DDRPIN_ST_IDLE;
        end
      end
      DDRPIN_ST_SELF: begin
        // Exit follows cke once it has crossed the synchroniser
        if (cke_s) begin
          next_state = DDRPIN_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state    <= DDRPIN_ST_IDLE;
      beat_cnt <= `DDRPIN_BEAT_ZERO;
      cke_d    <= 1'b0;
    end else begin
      state    <= next_state;
      beat_cnt <= next_beat_cnt;
      cke_d    <= cke_s;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cur_bank <= `DDRPIN_BANK_RST;
      col      <= '0;
    end else if (is_rd || is_wr) begin
      cur_bank <= ba_s;
      col      <= addr_s[COL_AW-1:0];
    end else if (state == DDRPIN_ST_READ || state == DDRPIN_ST_WRITE) begin
      col      <= col + COL_AW'(1);
    end
  end

  //------------------------------------------------------------
  // Storage
  //------------------------------------------------------------
  // Only the low column bits are kept; array is a behavioural stand-in
  wire                wr_beat = (state == DDRPIN_ST_WRITE) && !dm_s;
  wire [7:0]          rd_byte;
  wire [COL_AW-1:0]   rd_addr = (is_rd) ? addr_s[COL_AW-1:0] : col + COL_AW'(1);

  ddrpin_mem #(.AW(COL_AW)) u_mem (
    .clk_sys (clk_sys),
    .wr_en   (wr_beat),
    .wr_addr (col),
    .wr_data (dq_s),
    .rd_addr (rd_addr),
    .rd_data (rd_byte)
  );

  //------------------------------------------------------------
  // Data and strobe drivers
  //------------------------------------------------------------
  wire reading = (state == DDRPIN_ST_READ);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dq_out    <= `DDRPIN_BYTE_RST;
      dq_oe_n   <= 1'b1;
      dqs_out   <= 1'b0;
      dqs_out_n <= 1'b1;
      dqs_oe_n  <= 1'b1;
    end else begin
      dq_out    <= reading ? rd_byte : `DDRPIN_BYTE_RST;
      dq_oe_n   <= !reading;
      // Strobe toggles with each data beat, so edges line up with data
      dqs_out   <= reading ? !dqs_out : 1'b0;
      dqs_out_n <= reading ? dqs_out : 1'b1;
      dqs_oe_n  <= !reading;
    end
  end

  //------------------------------------------------------------
  // Termination and command status
  //------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      {term_dq, term_dqs, term_dm_tdqs, term_tdqs_n} <= 4'h0;
      term_ca      <= 1'b0;
      tdqs_mode    <= 1'b0;
      self_refresh <= 1'b0;
    end else begin
      term_dq      <= odt_eff;
      term_dqs     <= odt_eff;
      term_dm_tdqs <= odt_eff;
      term_tdqs_n  <= odt_eff && tdqs_en;
      term_ca      <= 1'b0;
      tdqs_mode    <= tdqs_en;
      self_refresh <= (next_state == DDRPIN_ST_SELF);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      auto_pre  <= 1'b0;
      pre_bank  <= `DDRPIN_BANK_RST;
      pre_all   <= 1'b0;
      pre_valid <= 1'b0;
      open_row  <= `DDRPIN_ADDR_RST;
      mrs_sel   <= `DDRPIN_BANK_RST;
      mrs_op    <= `DDRPIN_ADDR_RST;
    end else begin
      // Auto precharge fires on the last beat of the burst
      pre_valid <= is_pre || (burst_last && auto_pre &&
                   (state == DDRPIN_ST_READ || state == DDRPIN_ST_WRITE));
      pre_all   <= is_pre && ap_bit;
      if (is_pre) begin
        pre_bank <= ba_s;
      end else if (burst_last) begin
        pre_bank <= cur_bank;
      end
      if (is_rd || is_wr) begin
        auto_pre <= ap_bit;
      end
      if (is_act) begin
        open_row <= addr_s;
      end
      if (is_mrs) begin
        mrs_sel <= ba_s;
        mrs_op  <= addr_s;
      end
    end
  end

  //------------------------------------------------------------
  // Assertions
  //------------------------------------------------------------
  sequence s_cmd_wr_chop;
    is_wr && chop && (state == DDRPIN_ST_IDLE);
  endsequence
  sequence s_four_beats;
    (state == DDRPIN_ST_WRITE) [*4] ##1 (state == DDRPIN_ST_IDLE);
  endsequence

  a_chop_four_beats: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_cmd_wr_chop |=> s_four_beats) else $error("chopped write not four beats");
  a_odt_self_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
    st_self |=> !term_dq) else $error("termination on in self refresh");
  a_cs_masks_cmd: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cs_n_s && state == DDRPIN_ST_IDLE) |=> state == DDRPIN_ST_IDLE)
    else $error("command taken with cs high");
  a_dq_drive_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !dq_oe_n |-> $past(reading)) else $error("dq driven outside read");
  a_strobe_diff: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !dqs_oe_n |-> (dqs_out_n == !dqs_out)) else $error("strobe pair not differential");
  a_tdqs_term: assert property (@(posedge clk_sys) disable iff (!arst_n)
    term_tdqs_n |-> tdqs_mode && term_dqs) else $error("tdqs_n terminated in dm mode");
  a_no_ca_term: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !term_ca) else $error("input pin terminated");
  a_pre_all_a10: assert property (@(posedge clk_sys) disable iff (!arst_n)
    is_pre |=> pre_valid && (pre_all == $past(ap_bit))) else $error("precharge scope wrong");
  a_mask_no_store: assert property (@(posedge clk_sys) disable iff (!arst_n)
    dm_s |-> !wr_beat) else $error("masked beat written");

endmodule
